// >>> hdl/clk_div.sv
// programmable divider counting source ticks; ratio is div_i + 1
// assumes tick_i is a one-cycle pulse in the clk_sys_i domain
`timescale 1ns/1ps
module clk_div #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // control
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic [WIDTH-1:0] div_i,
    // divided outputs
    output logic level_o,
    output logic rise_o
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH:0] half;

    // high for the first half of each period, longer half low on odd ratios
    assign half = ({1'b0, div_i} + {{WIDTH{1'b0}}, 1'b1}) >> 1;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (clear_i) begin
            cnt_q <= '0;
        end else if (tick_i) begin
            cnt_q <= (cnt_q >= div_i) ? '0 : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            rise_o <= tick_i && !clear_i && (cnt_q == '0);
            if (clear_i) begin
                level_o <= 1'b0;
            end else if (tick_i) begin
                level_o <= ({1'b0, cnt_q} < half) || (div_i == '0);
            end
        end
    end
endmodule

// >>> hdl/clkgen_defs.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the design files
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define CG_REG_PLL_ON 8'h04
`define CG_REG_REF_SEL 8'h0D
`define CG_REG_PREDIV 8'h14
`define CG_REG_JMULT 8'h15
`define CG_REG_FRAC_HI 8'h16
`define CG_REG_FRAC_LO 8'h17
`define CG_REG_POSTMULT 8'h18
`define CG_REG_PROC_DIV 8'h1B
`define CG_REG_BCLK_DIV 8'h20
`define CG_REG_WCLK_DIV 8'h21
`define CG_REG_AUTO_CTRL 8'h25
`define CG_REG_STATUS 8'h5E

// ****************************************
// field positions
// ****************************************
`define CG_PLL_ON_BIT 0
`define CG_REF_LSB 4
`define CG_REF_MSB 6
`define CG_AUTO_OFF_BIT 0
`define CG_IGN_ERR_BIT 1
`define CG_MASTER_BIT 2
`define CG_ST_CLK_ERR_BIT 0
`define CG_ST_COEFF_BAD_BIT 1
`define CG_ST_AUTO_ACT_BIT 2
`define CG_ST_PENDING_BIT 3

// ****************************************
// reset values and limits
// ****************************************
`define CG_PLL_ON_RST 1'b1
`define CG_J_MIN 6'h04
`define CG_J_FRAC_MAX 6'h0B
`define CG_D_MAX 14'h270F
`define CG_R_ONE 4'h1
`define CG_DIV7_RST 7'h03
`define CG_DIV8_RST 8'h3F

// ****************************************
// timing
// ****************************************
`define CG_SYS_CLK_HZ 50000000
`define CG_FS_SINGLE_MAX_HZ 48000
`define CG_CLK_TIMEOUT_US 1000

`endif

// >>> hdl/clkgen_pkg.sv
// types shared by the clock generation block
// assumes clkgen_defs.svh supplies the numbers
package clkgen_pkg;

    // ****************************************
    // reference choice
    // ****************************************
    typedef enum logic [2:0] {
        REF_MCLK = 3'h0,
        REF_SCLK = 3'h1,
        REF_GPIO = 3'h3
    } ref_src_t;

    // ****************************************
    // pll coefficient set
    // ****************************************
    typedef struct packed {
        logic [3:0] p;
        logic [5:0] j;
        logic [13:0] d;
        logic [3:0] r;
    } pll_coeff_t;

    typedef enum logic [1:0] {
        RATIO_128,
        RATIO_192,
        RATIO_STD,
        RATIO_BAD
    } ratio_class_t;

endpackage

// >>> hdl/clkgen_top.sv
// pll configuration, reference choice, auto clocking and output dividers
// assumes the analog pll returns one synchronous pulse per output period
//
// How it works
// - manual coefficients allow any 1-50 MHz mclk
// - clock error detection can be ignored
// - master mode drives bit and word clocks
// - 256/384/512 direct; 128/192 need pll
// - three-bit reference select at 13[6:4]
// - pll off means external mclk used
// - pll enable resets to on
// - pll out equals in times R.J.D over P
// - bad R, J, D, P combinations flagged in status while pll is on, still sent to pll
// - reference from 1 to 50 MHz accepted
// - sample rate is vco over 2048
// - coefficient fields at fixed register places
// - dividers for processor, bit and word clocks
// - auto mode configures pll from valid clocks
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module clkgen_top #(
    parameter int CLK_TIMEOUT_CYC = `CG_CLK_TIMEOUT_US * (`CG_SYS_CLK_HZ / 1000000),
    parameter int RATIO_W = 10
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // clock pins and pll feedback
    input wire logic mclk_i,
    input wire logic sclk_i,
    input wire logic wclk_i,
    input wire logic gpio_ref_i,
    input wire logic pll_tick_i,
    // pll controls
    output logic pll_on_bit_o,
    output logic [2:0] ref_select_o,
    output clkgen_pkg::pll_coeff_t pll_coeff_o,
    output logic pll_in_clock_o,
    // derived clocks
    output logic proc_clk_en_o,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic wclk_o,
    output logic wclk_oe_o,
    output logic clk_err_o
);
    localparam int FS_MIN_PERIOD = `CG_SYS_CLK_HZ / `CG_FS_SINGLE_MAX_HZ;

    // ****************************************
    // register file
    // ****************************************
    logic pll_on_q;
    logic [2:0] ref_sel_q;
    logic [3:0] p_q;
    logic [5:0] j_q;
    logic [5:0] d_hi_q;
    logic [7:0] d_lo_q;
    logic [3:0] r_q;
    logic [6:0] proc_div_q;
    logic [6:0] bclk_div_q;
    logic [7:0] wclk_div_q;
    logic auto_off_q;
    logic ign_err_q;
    logic master_q;
    logic pending_q;
    clkgen_pkg::pll_coeff_t active_q;
    logic [7:0] status;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pll_on_q <= `CG_PLL_ON_RST;
            ref_sel_q <= clkgen_pkg::REF_MCLK;
            p_q <= 4'h1;
            j_q <= 6'h08;
            d_hi_q <= 6'h00;
            d_lo_q <= 8'h00;
            r_q <= `CG_R_ONE;
            proc_div_q <= `CG_DIV7_RST;
            bclk_div_q <= `CG_DIV7_RST;
            wclk_div_q <= `CG_DIV8_RST;
            auto_off_q <= 1'b0;
            ign_err_q <= 1'b0;
            master_q <= 1'b0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `CG_REG_PLL_ON: pll_on_q <= reg_wdata_i[`CG_PLL_ON_BIT];
                `CG_REG_REF_SEL: ref_sel_q <= reg_wdata_i[`CG_REF_MSB:`CG_REF_LSB];
                `CG_REG_PREDIV: p_q <= reg_wdata_i[3:0];
                `CG_REG_JMULT: j_q <= reg_wdata_i[5:0];
                `CG_REG_FRAC_HI: d_hi_q <= reg_wdata_i[5:0];
                `CG_REG_FRAC_LO: d_lo_q <= reg_wdata_i;
                `CG_REG_POSTMULT: r_q <= reg_wdata_i[3:0];
                `CG_REG_PROC_DIV: proc_div_q <= reg_wdata_i[6:0];
                `CG_REG_BCLK_DIV: bclk_div_q <= reg_wdata_i[6:0];
                `CG_REG_WCLK_DIV: wclk_div_q <= reg_wdata_i;
                `CG_REG_AUTO_CTRL: begin
                    auto_off_q <= reg_wdata_i[`CG_AUTO_OFF_BIT];
                    ign_err_q <= reg_wdata_i[`CG_IGN_ERR_BIT];
                    master_q <= reg_wdata_i[`CG_MASTER_BIT];
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // coefficient staging
    // ****************************************
    logic coeff_wr;
    logic commit;

    // partial updates never reach the pll; the R write closes a set
    assign coeff_wr = reg_wr_i && (reg_addr_i >= `CG_REG_PREDIV)
        && (reg_addr_i <= `CG_REG_POSTMULT);
    assign commit = reg_wr_i && (reg_addr_i == `CG_REG_POSTMULT);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            active_q <= '{p: 4'h1, j: 6'h08, d: 14'h0000, r: `CG_R_ONE};
            pending_q <= 1'b0;
        end else begin
            pending_q <= coeff_wr && !commit ? 1'b1 : (commit ? 1'b0 : pending_q);
            if (commit) begin
                active_q <= '{p: p_q, j: j_q, d: {d_hi_q, d_lo_q},
                    r: reg_wdata_i[3:0]};
            end
        end
    end

    // range check on the committed set; r of zero stands for sixteen
    logic coeff_bad;
    always_comb begin
        coeff_bad = (active_q.p == 4'h0) || (active_q.j < `CG_J_MIN);
        if (active_q.d > `CG_D_MAX) begin
            coeff_bad = 1'b1;
        end
        if (active_q.d != 14'h0000) begin
            if (active_q.j > `CG_J_FRAC_MAX || active_q.r != `CG_R_ONE) begin
                coeff_bad = 1'b1;
            end
        end
    end

    // ****************************************
    // input edges
    // ****************************************
    logic mclk_q;
    logic sclk_q;
    logic wclk_q;
    logic gpio_q;
    logic mclk_rise;
    logic wclk_rise;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mclk_q <= 1'b0;
            sclk_q <= 1'b0;
            wclk_q <= 1'b0;
            gpio_q <= 1'b0;
        end else begin
            mclk_q <= mclk_i;
            sclk_q <= sclk_i;
            wclk_q <= wclk_i;
            gpio_q <= gpio_ref_i;
        end
    end

    assign mclk_rise = mclk_i && !mclk_q;
    assign wclk_rise = wclk_i && !wclk_q;

    // ****************************************
    // ratio detection for auto mode
    // ****************************************
    logic [RATIO_W-1:0] mclk_cnt_q;
    logic [RATIO_W-1:0] ratio_q;
    logic [15:0] per_cnt_q;
    logic [15:0] period_q;
    logic [$clog2(CLK_TIMEOUT_CYC+1)-1:0] idle_cnt_q;
    logic clk_lost_q;
    clkgen_pkg::ratio_class_t ratio_class;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mclk_cnt_q <= '0;
            ratio_q <= '0;
            per_cnt_q <= 16'h0000;
            period_q <= 16'h0000;
        end else if (wclk_rise) begin
            ratio_q <= mclk_cnt_q + (mclk_rise ? 1'b1 : 1'b0);
            mclk_cnt_q <= '0;
            period_q <= per_cnt_q;
            per_cnt_q <= 16'h0001;
        end else begin
            if (mclk_rise && mclk_cnt_q != '1) begin
                mclk_cnt_q <= mclk_cnt_q + 1'b1;
            end
            if (per_cnt_q != 16'hFFFF) begin
                per_cnt_q <= per_cnt_q + 16'h0001;
            end
        end
    end

    // missing mclk or word clock for too long counts as a clock error
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt_q <= '0;
            clk_lost_q <= 1'b1;
        end else if (wclk_rise && ratio_q != '0) begin
            idle_cnt_q <= '0;
            clk_lost_q <= 1'b0;
        end else if (int'(idle_cnt_q) >= CLK_TIMEOUT_CYC) begin
            clk_lost_q <= 1'b1;
        end else begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    always_comb begin
        unique case (ratio_q)
            RATIO_W'(256), RATIO_W'(384), RATIO_W'(512): ratio_class = clkgen_pkg::RATIO_STD;
            RATIO_W'(128): ratio_class = clkgen_pkg::RATIO_128;
            RATIO_W'(192): ratio_class = clkgen_pkg::RATIO_192;
            default: ratio_class = clkgen_pkg::RATIO_BAD;
        endcase
    end

    logic ratio_ok;
    // 192 fs only at single rate; short word periods mean above 48 kHz
    assign ratio_ok = (ratio_class == clkgen_pkg::RATIO_STD)
        || (ratio_class == clkgen_pkg::RATIO_128 && pll_on_q)
        || (ratio_class == clkgen_pkg::RATIO_192 && pll_on_q
            && int'(period_q) >= FS_MIN_PERIOD);

    // auto set targets a vco of 2048 fs from mclk with integer k
    clkgen_pkg::pll_coeff_t auto_coeff;
    always_comb begin
        auto_coeff = '{p: 4'h1, j: 6'h08, d: 14'h0000, r: `CG_R_ONE};
        unique case (ratio_q)
            RATIO_W'(128): auto_coeff.j = 6'h10;
            RATIO_W'(192): begin
                auto_coeff.j = 6'h20;
                auto_coeff.p = 4'h3;
            end
            RATIO_W'(384): begin
                auto_coeff.j = 6'h10;
                auto_coeff.p = 4'h3;
            end
            RATIO_W'(512): auto_coeff.j = 6'h04;
            default: ;
        endcase
    end

    logic auto_act;
    logic clk_err;
    logic err_eff;
    assign auto_act = !auto_off_q && !clk_lost_q && ratio_ok;
    // manual mode trusts software for any 1-50 MHz mclk
    assign clk_err = auto_off_q ? (clk_lost_q && !master_q)
        : (clk_lost_q || !ratio_ok);
    assign err_eff = clk_err && !ign_err_q;

    // ****************************************
    // pll control outputs
    // ****************************************
    logic ref_level;
    always_comb begin
        unique case (auto_act ? clkgen_pkg::REF_MCLK : ref_sel_q)
            clkgen_pkg::REF_SCLK: ref_level = sclk_q;
            clkgen_pkg::REF_GPIO: ref_level = gpio_q;
            default: ref_level = mclk_q;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pll_on_bit_o <= `CG_PLL_ON_RST;
            ref_select_o <= clkgen_pkg::REF_MCLK;
            pll_coeff_o <= '{p: 4'h1, j: 6'h08, d: 14'h0000, r: `CG_R_ONE};
            pll_in_clock_o <= 1'b0;
            clk_err_o <= 1'b0;
        end else begin
            pll_on_bit_o <= pll_on_q;
            ref_select_o <= auto_act ? clkgen_pkg::REF_MCLK : ref_sel_q;
            pll_coeff_o <= auto_act ? auto_coeff : active_q;
            pll_in_clock_o <= ref_level;
            clk_err_o <= err_eff;
        end
    end

    // ****************************************
    // clock tree dividers
    // ****************************************
    logic src_tick;
    logic proc_level;
    logic proc_rise;
    logic bclk_level;
    logic bclk_rise;
    logic wclk_level;
    // with the pll off the tree runs straight from mclk
    assign src_tick = pll_on_q ? pll_tick_i : mclk_rise;

    clk_div #(
        .WIDTH(7)
    ) u_proc_div (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(src_tick),
        .clear_i(err_eff),
        .div_i(proc_div_q),
        .level_o(proc_level),
        .rise_o(proc_rise)
    );

    clk_div #(
        .WIDTH(7)
    ) u_bclk_div (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(src_tick),
        .clear_i(!master_q),
        .div_i(bclk_div_q),
        .level_o(bclk_level),
        .rise_o(bclk_rise)
    );

    clk_div #(
        .WIDTH(8)
    ) u_wclk_div (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(bclk_rise),
        .clear_i(!master_q),
        .div_i(wclk_div_q),
        .level_o(wclk_level),
        .rise_o()
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            proc_clk_en_o <= 1'b0;
            sclk_o <= 1'b0;
            sclk_oe_o <= 1'b0;
            wclk_o <= 1'b0;
            wclk_oe_o <= 1'b0;
        end else begin
            proc_clk_en_o <= proc_rise && !err_eff;
            sclk_o <= bclk_level && master_q;
            sclk_oe_o <= master_q;
            wclk_o <= wclk_level && master_q;
            wclk_oe_o <= master_q;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    assign status = {4'h0, pending_q, auto_act, coeff_bad && pll_on_q, clk_err};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `CG_REG_PLL_ON: reg_rdata_o <= {7'h00, pll_on_q};
                `CG_REG_REF_SEL: reg_rdata_o <= {1'b0, ref_sel_q, 4'h0};
                `CG_REG_PREDIV: reg_rdata_o <= {4'h0, p_q};
                `CG_REG_JMULT: reg_rdata_o <= {2'h0, j_q};
                `CG_REG_FRAC_HI: reg_rdata_o <= {2'h0, d_hi_q};
                `CG_REG_FRAC_LO: reg_rdata_o <= d_lo_q;
                `CG_REG_POSTMULT: reg_rdata_o <= {4'h0, r_q};
                `CG_REG_PROC_DIV: reg_rdata_o <= {1'b0, proc_div_q};
                `CG_REG_BCLK_DIV: reg_rdata_o <= {1'b0, bclk_div_q};
                `CG_REG_WCLK_DIV: reg_rdata_o <= wclk_div_q;
                `CG_REG_AUTO_CTRL: reg_rdata_o <= {5'h00, master_q, ign_err_q, auto_off_q};
                `CG_REG_STATUS: reg_rdata_o <= status;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// >>> testbench/clkgen_checker.sv
// assertions on the register port and derived clock pins
// assumes binding to clkgen_top; sees only its ports
`timescale 1ns/1ps
module clkgen_checker (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // pll and clocks
    input wire logic pll_on_bit_o,
    input wire logic [2:0] ref_select_o,
    input wire clkgen_pkg::pll_coeff_t pll_coeff_o,
    input wire logic proc_clk_en_o,
    input wire logic sclk_o,
    input wire logic sclk_oe_o,
    input wire logic wclk_o,
    input wire logic wclk_oe_o,
    input wire logic clk_err_o
);
    // ****************************************
    // helper state
    // ****************************************
    logic auto_off_q;
    logic [1:0] r_wr_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) auto_off_q <= 1'b0;
        else if (reg_wr_i && reg_addr_i == 8'h25) auto_off_q <= reg_wdata_i[0];
    end
    // commits land two cycles late, so staged writes near one are excluded
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) r_wr_q <= 2'b00;
        else r_wr_q <= {r_wr_q[0], reg_wr_i && reg_addr_i == 8'h18};
    end
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_man;
        auto_off_q && $past(auto_off_q);
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_pll_on_write: assert property (s_wr(8'h04)
        |-> ##2 pll_on_bit_o == $past(reg_wdata_i[0], 2))
        else $error("pll enable does not follow write");
    a_pll_on_reset: assert property ($fell(rst_i) |-> pll_on_bit_o && ref_select_o == 3'h0
        && pll_coeff_o == 28'h1200001) else $error("reset values wrong");
    a_ref_write: assert property ((s_wr(8'h0D) ##0 s_man)
        ##0 (reg_wdata_i[6:4] inside {3'h0, 3'h1, 3'h3})
        |-> ##2 ref_select_o == $past(reg_wdata_i[6:4], 2)) else $error("reference select wrong");
    a_commit_delay: assert property ((s_wr(8'h18) ##0 s_man)
        |-> ##2 pll_coeff_o.r == $past(reg_wdata_i[3:0], 2)) else $error("commit late");
    a_staged_hold: assert property ((reg_wr_i && reg_addr_i inside {[8'h14:8'h17]}
        && r_wr_q == 2'b00) ##0 s_man |=> $stable(pll_coeff_o))
        else $error("coefficients changed before commit");
    a_master_idle: assert property (!sclk_oe_o |-> !sclk_o && !wclk_o)
        else $error("clock outputs active while slave");
    a_oe_pair: assert property (sclk_oe_o == wclk_oe_o) else $error("enables differ");
    a_err_quiet: assert property (clk_err_o && $past(clk_err_o) |-> !proc_clk_en_o)
        else $error("processor clock during clock error");
endmodule

bind clkgen_top clkgen_checker i_chk (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .pll_on_bit_o, .ref_select_o, .pll_coeff_o, .proc_clk_en_o, .sclk_o, .sclk_oe_o, .wclk_o,
    .wclk_oe_o, .clk_err_o);

// >>> testbench/host_clk_model.sv
// host serial port clock source: master, bit, word, gpio clocks and pll ticks
// assumes clk_sys_i at 50 MHz; all clocks freeze while run_i is low
`timescale 1ns/1ps
module host_clk_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    // clocks to the device
    output logic mclk_o,
    output logic sclk_o,
    output logic wclk_o,
    output logic gpio_ref_o,
    output logic pll_tick_o
);
    logic [9:0] cnt_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) cnt_q <= 10'h000;
        else if (run_i) cnt_q <= cnt_q + 10'h001;
    end
    assign mclk_o = cnt_q[1];
    assign sclk_o = cnt_q[3];
    assign wclk_o = cnt_q[9];
    assign gpio_ref_o = cnt_q[2];
    // a stand-in for the analog pll, one tick per eight system cycles
    assign pll_tick_o = run_i && cnt_q[2:0] == 3'h0;
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for clkgen_top with a host clock source model
// assumes the design and checker are compiled before this file
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, run;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
    logic mclk, sclk, wclk, gpio, tick, pll_on_bit_o, pll_in_clock_o, proc_clk_en_o;
    logic sclk_o, sclk_oe_o, wclk_o, wclk_oe_o, clk_err_o;
    logic [2:0] ref_select_o;
    clkgen_pkg::pll_coeff_t pll_coeff_o;
    logic [39:0] cs[3] = '{40'h01_07_D4_90_01, 40'h01_08_07_80_01, 40'h0F_3F_27_0F_00};
    logic [23:0] ex[3] = '{24'h11D490, 24'h120780, 24'hFFE70F};
    logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h3};
    int n_errors, num_checks, cyc, n;
    host_clk_model i_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run), .mclk_o(mclk),
        .sclk_o(sclk), .wclk_o(wclk), .gpio_ref_o(gpio), .pll_tick_o(tick));
    // shorter clock timeout keeps the run brief
    clkgen_top #(.CLK_TIMEOUT_CYC(2000)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mclk_i(mclk), .sclk_i(sclk),
        .wclk_i(wclk), .gpio_ref_i(gpio), .pll_tick_i(tick), .pll_on_bit_o(pll_on_bit_o),
        .ref_select_o(ref_select_o), .pll_coeff_o(pll_coeff_o), .pll_in_clock_o(pll_in_clock_o),
        .proc_clk_en_o(proc_clk_en_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .wclk_o(wclk_o),
        .wclk_oe_o(wclk_oe_o), .clk_err_o(clk_err_o));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 q = reg_rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(q, e);
    endtask
    // cycles between two rising edges of the bit or word clock output
    task automatic per(input bit w, output int n);
        logic p, c;
        int r1;
        r1 = 0;
        n = 0;
        p = 1'b1;
        for (int k = 1; k < 600 && n == 0; k++) begin
            @(posedge clk_sys_i);
            c = w ? wclk_o : sclk_o;
            if (p === 1'b0 && c === 1'b1) begin
                if (r1 > 0) n = k - r1;
                else r1 = k;
            end
            p = c;
        end
    endtask
    // ****************************************
    // clock, timeout and sequence
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        {n_errors, num_checks, cyc} = '0;
        {rst_i, run, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {2'b11, 18'h0};
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(8'h04, 8'h01);
        rdc(8'h1B, 8'h03);
        rdc(8'h20, 8'h03);
        rdc(8'h21, 8'h3F);
        rdc(8'h30, 8'h00);
        repeat (4000) @(posedge clk_sys_i);
        rd(8'h5E);
        chk(q[2], 1'b1);
        chk(pll_coeff_o, 28'h1200001);
        wr(8'h25, 8'h01);
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 4; b++) wr(8'(8'h14 + b), cs[i][39 - 8 * b -: 8]);
            chk(pll_coeff_o[27:4], i == 0 ? 24'h120000 : ex[i - 1]);
            rd(8'h5E);
            chk(q[3], 1'b1);
            wr(8'h18, cs[i][7:0]);
            repeat (2) @(posedge clk_sys_i);
            #1 chk(pll_coeff_o[27:4], ex[i]);
            rd(8'h5E);
            chk({q[3], q[1]}, {1'b0, i == 2});
        end
        rdc(8'h16, 8'h27);
        rdc(8'h15, 8'h3F);
        for (int i = 0; i < 3; i++) begin
            wr(8'h0D, {1'b0, codes[i], 4'h0});
            repeat (2) @(posedge clk_sys_i);
            chk(ref_select_o, codes[i]);
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys_i);
            #1 q[0] = gpio;
            repeat (2) @(posedge clk_sys_i);
            #1 chk(pll_in_clock_o, q[0]);
        end
        wr(8'h25, 8'h07);
        wr(8'h20, 8'h01);
        wr(8'h21, 8'h03);
        chk(sclk_oe_o, 1'b1);
        per(0, n);
        chk(n, 16);
        per(1, n);
        chk(n, 64);
        n = 0;
        repeat (64) begin
            @(posedge clk_sys_i);
            #1 n += int'(proc_clk_en_o);
        end
        chk(n, 2);
        wr(8'h04, 8'h00);
        rdc(8'h04, 8'h00);
        chk(pll_on_bit_o, 1'b0);
        per(0, n);
        chk(n, 8);
        wr(8'h04, 8'h01);
        wr(8'h25, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        chk({sclk_oe_o, sclk_o, wclk_o}, 3'h0);
        wr(8'h25, 8'h00);
        run <= 1'b0;
        repeat (2500) @(posedge clk_sys_i);
        chk(clk_err_o, 1'b1);
        wr(8'h25, 8'h02);
        repeat (3) @(posedge clk_sys_i);
        chk(clk_err_o, 1'b0);
        rd(8'h5E);
        chk(q[0], 1'b1);
        run <= 1'b1;
        conclude();
    end
endmodule
